// >>> common/cpic_pkg.sv
// Purpose: constants and types for the core and peripheral interrupt controller
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: register port is a plain select/write/read port, no public bus
// Function
// - seventeen core sources prioritised, emulator included
// - bit n slot, vector steps 0x20
// - user slot zero highest, eleven lowest
// - pending ANDed with mask, highest picked
// - nmi ignore mask; disable blocks power-down
// - control register: nesting and global enable
// - nesting lets higher preempt, else sequential
// - pending register writes force and clear
// - status saved and restored on stacks
// - pc stack 33, loop 8, status 16
// - stack irq below 3 but not empty, or above 28
// - enable/disable all override the control register global enable bit
// - global servicing off after reset
// - no peripheral routed after reset
// - thirty-two peripheral request lines handled
// - eight 16-bit registers, four 4-bit fields
// - codes 0x0..0xB select same slot
// - codes 0xC..0xF leave source unconnected
// - slots may be shared; software finds requester
package cpic_pkg;
    localparam int CPIC_NSLOT    = 16;
    localparam int CPIC_NUSR     = 12;
    localparam int CPIC_USR_BASE = 4;
    localparam int CPIC_NPER     = 32;
    localparam int CPIC_NROUTE   = 8;
    localparam int CPIC_PC_DEPTH = 33;
    localparam int CPIC_LP_DEPTH = 8;
    localparam int CPIC_ST_DEPTH = 16;
    localparam int CPIC_PC_LOW   = 3;
    localparam int CPIC_PC_HIGH  = 28;
    localparam logic [23:0] CPIC_VEC_STEP = 24'h00_0020;
    localparam logic [3:0]  CPIC_CODE_MAX = 4'hB;
    localparam logic [3:0]  CPIC_ROUTE_OFF = 4'h_F;
    localparam logic [15:0] CPIC_ROUTE_RST = 16'hFFFF;
    localparam logic [15:0] CPIC_MASK_RST  = 16'h0000;
    // slot positions
    localparam int CPIC_SLOT_RESET = 0;
    localparam int CPIC_SLOT_PWRDN = 1;
    localparam int CPIC_SLOT_STACK = 2;
    localparam int CPIC_SLOT_EMUK  = 3;
    // register addresses on the register port
    localparam logic [3:0] CPIC_A_MASK    = 4'h0;
    localparam logic [3:0] CPIC_A_PENDING = 4'h1;
    localparam logic [3:0] CPIC_A_CONTROL = 4'h2;
    localparam logic [3:0] CPIC_A_STATUS  = 4'h3;
    localparam logic [3:0] CPIC_A_ROUTE0  = 4'h8;
    // control register fields
    localparam int CPIC_CTL_NEST = 0;
    localparam int CPIC_CTL_GIE  = 1;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } cpic_reg_req_t;

    typedef struct packed {
        logic        enter;   // sequencer takes the presented vector
        logic        leave;   // handler return
        logic        ena_int;
        logic        dis_int;
        logic        push;    // pc stack push (call/loop)
        logic        pop;
        logic        loop_push;
        logic        loop_pop;
    } cpic_seq_t;

    typedef enum logic [1:0] {
        CPIC_IDLE = 2'b00,
        CPIC_REQ  = 2'b01,
        CPIC_ACK  = 2'b11
    } cpic_state_t;
endpackage : cpic_pkg

// >>> src/cpic_ctrl.sv
// Purpose: core interrupt prioritiser plus peripheral routing unit
// Assumes: peripheral requests are asynchronous levels, sequencer on core_clk
// Notes: vector presented with irq_req until sequencer pulses enter or no candidate remains
`timescale 1ns/1ps
module cpic_ctrl #(
    parameter int NPER = 32
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire cpic_pkg::cpic_reg_req_t reg_req,
    output logic [15:0]                  reg_rdata,
    input  wire logic [NPER-1:0]         periph_req,
    input  wire logic                    emu_req,
    input  wire logic                    pwrdn_req,
    input  wire logic                    emu_kernel_req,
    input  wire cpic_pkg::cpic_seq_t     seq,
    input  wire logic [15:0]             status_in,
    output logic                         irq_req,
    output logic                         emu_irq,
    output logic [23:0]                  irq_vector,
    output logic [15:0]                  status_out,
    output logic                         status_valid,
    output logic                         stack_fault
);
    import cpic_pkg::*;

    initial begin
        if (NPER < 1 || NPER > CPIC_NPER)
            $error("NPER out of range");
    end

    logic [NPER-1:0]  per_s1;
    logic [NPER-1:0]  per_s2;
    logic             emu_s1, emu_s2, pd_s1, pd_s2, ek_s1, ek_s2;
    logic [15:0]      route [CPIC_NROUTE];
    logic [15:0]      core_irq_mask;
    logic [15:0]      core_irq_pending;
    logic [15:0]      irq_control_reg;
    logic [15:0]      active;           // handlers in service
    logic [15:0]      stat_stack [CPIC_ST_DEPTH];
    logic [4:0]       st_cnt;
    logic [5:0]       pc_cnt;
    logic [3:0]       lp_cnt;
    logic [11:0]      usr_req;
    logic [15:0]      hw_set;
    logic [15:0]      eligible;
    logic             found;
    logic [3:0]       win;
    cpic_state_t      state;

    function automatic logic [3:0] route_code(input int n);
        logic [15:0] r;
        r = route[n / 4];
        return r[4 * (n % 4) +: 4];
    endfunction : route_code

    function automatic logic [3:0] first_set(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = CPIC_NSLOT - 1; i >= 0; i--)
            if (v[i])
                idx = 4'(i);
        return idx;
    endfunction : first_set

    // pins from the peripheral side are asynchronous
    always_ff @(posedge core_clk) begin
        per_s1 <= periph_req;
        per_s2 <= per_s1;
        emu_s1 <= emu_req;
        emu_s2 <= emu_s1;
        pd_s1  <= pwrdn_req;
        pd_s2  <= pd_s1;
        ek_s1  <= emu_kernel_req;
        ek_s2  <= ek_s1;
    end

    // shared slots simply OR; software sorts out the requester
    always_comb begin
        usr_req = '0;
        for (int n = 0; n < NPER; n++)
            if (route_code(n) <= CPIC_CODE_MAX)
                usr_req[route_code(n)] =
                    usr_req[route_code(n)] | per_s2[n];
    end

    always_comb begin
        hw_set = '0;
        hw_set[CPIC_USR_BASE +: CPIC_NUSR] = usr_req;
        hw_set[CPIC_SLOT_PWRDN] = pd_s2;
        hw_set[CPIC_SLOT_EMUK]  = ek_s2;
        hw_set[CPIC_SLOT_STACK] = stack_fault;
    end

    // selection: mask gate, nmi bypass, global enable, nesting
    always_comb begin
        logic [15:0] gated;
        logic [15:0] higher;
        gated = core_irq_pending & core_irq_mask;
        gated[CPIC_SLOT_RESET] = core_irq_pending[CPIC_SLOT_RESET];
        gated[CPIC_SLOT_PWRDN] = core_irq_pending[CPIC_SLOT_PWRDN];
        if (!irq_control_reg[CPIC_CTL_GIE])
            gated = gated & (16'h0001 << CPIC_SLOT_RESET);
        higher = '0;
        for (int i = 0; i < CPIC_NSLOT; i++)
            if (active[i])
                higher = higher | ((16'h0001 << i) - 16'h0001);
        if (active == '0)
            eligible = gated;
        else if (irq_control_reg[CPIC_CTL_NEST])
            eligible = gated & higher;
        else
            eligible = gated & (16'h0001 << CPIC_SLOT_RESET);
        found = |eligible;
        win   = first_set(eligible);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < CPIC_NROUTE; i++)
                route[i] <= CPIC_ROUTE_RST;
        end else if (reg_req.sel && reg_req.wr
                     && reg_req.addr >= CPIC_A_ROUTE0) begin
            route[3'(reg_req.addr - CPIC_A_ROUTE0)] <= reg_req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_irq_mask   <= CPIC_MASK_RST;
            irq_control_reg <= '0;
        end else begin
            if (reg_req.sel && reg_req.wr && reg_req.addr == CPIC_A_MASK)
                core_irq_mask <= reg_req.wdata;
            if (reg_req.sel && reg_req.wr
                && reg_req.addr == CPIC_A_CONTROL)
                irq_control_reg <= reg_req.wdata;
            if (seq.ena_int)
                irq_control_reg[CPIC_CTL_GIE] <= 1'b1;
            if (seq.dis_int)
                irq_control_reg[CPIC_CTL_GIE] <= 1'b0;
        end
    end

    // hardware sets win over a software clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_irq_pending <= '0;
        end else begin
            logic [15:0] p;
            p = core_irq_pending;
            if (reg_req.sel && reg_req.wr
                && reg_req.addr == CPIC_A_PENDING)
                p = reg_req.wdata;
            if (state == CPIC_REQ && seq.enter)
                p[win] = 1'b0;
            core_irq_pending <= p | hw_set;
        end
    end

    // handshake with the sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state      <= CPIC_IDLE;
            irq_req    <= 1'b0;
            irq_vector <= '0;
            active     <= '0;
        end else begin
            case (state)
                CPIC_IDLE: begin
                    if (found) begin
                        state      <= CPIC_REQ;
                        irq_req    <= 1'b1;
                        irq_vector <= 24'(win) * CPIC_VEC_STEP;
                    end
                end
                CPIC_REQ: begin
                    // vector follows the best candidate until taken
                    irq_vector <= 24'(win) * CPIC_VEC_STEP;
                    if (seq.enter) begin
                        state   <= CPIC_ACK;
                        irq_req <= 1'b0;
                        // a return in the same cycle must not be lost
                        active  <= (seq.leave ? active & (active - 16'h0001)
                                    : active) | (16'h0001 << win);
                    end else if (!found) begin
                        state   <= CPIC_IDLE;
                        irq_req <= 1'b0;
                    end
                end
                CPIC_ACK: state <= CPIC_IDLE;
                default: state <= CPIC_IDLE;
            endcase
            if (seq.leave && !(state == CPIC_REQ && seq.enter))
                active <= active & (active - 16'h0001);  // drop lowest index
        end
    end

    // emulator is above everything and never masked
    always_ff @(posedge core_clk) begin
        if (reset)
            emu_irq <= 1'b0;
        else
            emu_irq <= emu_s2;
    end

    // status stack: push on entry, pop on return in a cycle without a push
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_cnt       <= '0;
            status_out   <= '0;
            status_valid <= 1'b0;
        end else begin
            status_valid <= 1'b0;
            if (state == CPIC_REQ && seq.enter
                && st_cnt < 5'(CPIC_ST_DEPTH)) begin
                stat_stack[st_cnt[3:0]] <= status_in;
                st_cnt <= st_cnt + 5'd1;
            end else if (seq.leave && st_cnt != '0) begin
                status_out   <= stat_stack[4'(st_cnt - 5'd1)];
                status_valid <= 1'b1;
                st_cnt       <= st_cnt - 5'd1;
            end
        end
    end

    // stack occupancy; saturating counters, the overflow itself is an error
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_cnt      <= '0;
            lp_cnt      <= '0;
            stack_fault <= 1'b0;
        end else begin
            if ((seq.push || (state == CPIC_REQ && seq.enter))
                && pc_cnt < 6'(CPIC_PC_DEPTH))
                pc_cnt <= pc_cnt + 6'd1;
            else if ((seq.pop || seq.leave) && pc_cnt != '0)
                pc_cnt <= pc_cnt - 6'd1;
            if (seq.loop_push && lp_cnt < 4'(CPIC_LP_DEPTH))
                lp_cnt <= lp_cnt + 4'd1;
            else if (seq.loop_pop && lp_cnt != '0)
                lp_cnt <= lp_cnt - 4'd1;
            // empty stack after reset is normal, so only flag while not empty
            stack_fault <= (pc_cnt != '0 && pc_cnt < 6'(CPIC_PC_LOW))
                        || pc_cnt > 6'(CPIC_PC_HIGH);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_req.sel && !reg_req.wr) begin
            case (reg_req.addr)
                CPIC_A_MASK:    reg_rdata <= core_irq_mask;
                CPIC_A_PENDING: reg_rdata <= core_irq_pending;
                CPIC_A_CONTROL: reg_rdata <= irq_control_reg;
                CPIC_A_STATUS:  reg_rdata <= {2'b00, pc_cnt, lp_cnt, win};
                default: begin
                    if (reg_req.addr >= CPIC_A_ROUTE0)
                        reg_rdata <= route[3'(reg_req.addr - CPIC_A_ROUTE0)];
                    else
                        reg_rdata <= '0;
                end
            endcase
        end
    end
endmodule : cpic_ctrl

// >>> testbench/cpic_ctrl_asserts.sv
// Purpose: port checks for cpic_ctrl
// Assumes: bound to the cpic_ctrl ports
// Notes: global enable is mirrored from writes and instructions
`timescale 1ns/1ps
module cpic_ctrl_asserts (
    input wire logic                    core_clk,
    input wire logic                    reset,
    input wire cpic_pkg::cpic_reg_req_t reg_req,
    input wire logic [15:0]             reg_rdata,
    input wire logic                    emu_req,
    input wire cpic_pkg::cpic_seq_t     seq,
    input wire logic                    irq_req,
    input wire logic                    emu_irq,
    input wire logic [23:0]             irq_vector,
    input wire logic                    status_valid,
    input wire logic                    stack_fault
);
    import cpic_pkg::*;
    logic       gie;
    logic [3:0] off_cnt;
    logic [1:0] stk_mv;
    wire        ctl_wr = reg_req.sel && reg_req.wr
                         && reg_req.addr == CPIC_A_CONTROL;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge core_clk) begin
        if (reset)
            gie <= 1'b0;
        else if (seq.ena_int || seq.dis_int)
            gie <= !seq.dis_int;
        else if (ctl_wr)
            gie <= reg_req.wdata[CPIC_CTL_GIE];
    end
    // saturates so a long disabled stretch cannot wrap back
    always_ff @(posedge core_clk) begin
        if (reset || gie)
            off_cnt <= 4'h0;
        else if (off_cnt != 4'hF)
            off_cnt <= off_cnt + 4'h1;
    end
    always_ff @(posedge core_clk) begin
        stk_mv <= {stk_mv[0], seq.push | seq.pop | seq.enter | seq.leave};
    end
    sequence s_take;
        irq_req && seq.enter;
    endsequence
    a_rst_quiet: assert property (disable iff (1'b0) reset
        |=> !irq_req && !status_valid && reg_rdata == 16'h0000)
        else $error("outputs not cleared by reset");
    a_vec_step: assert property (irq_req
        |-> irq_vector[4:0] == 5'h00 && irq_vector[23:9] == 15'h0000)
        else $error("vector off the slot grid");
    a_gdis_block: assert property (off_cnt > 4'h3 && irq_req
        |-> irq_vector == 24'h00_0000)
        else $error("served while globally disabled");
    a_unmap_zero: assert property (reg_req.sel && !reg_req.wr
        && reg_req.addr[3:2] == 2'b01 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_enter_drop: assert property (s_take |=> !irq_req)
        else $error("request stays after entry");
    a_status_cause: assert property (status_valid
        |-> $past(seq.leave) || $past(seq.leave, 2))
        else $error("status restored without a return");
    a_emu_follow: assert property ($rose(emu_req) |-> ##[1:4] emu_irq)
        else $error("emulator request not passed on");
    a_fault_cause: assert property ($changed(stack_fault)
        |-> stk_mv != 2'b00)
        else $error("stack fault moved without stack traffic");
endmodule : cpic_ctrl_asserts

// >>> testbench/cpic_ctrl_tb.sv
// Purpose: self-checking bench for cpic_ctrl
// Assumes: sequencer model takes every presented vector
// Notes: requests are short pulses so each is taken once
`timescale 1ns/1ps
module cpic_ctrl_tb;
    import cpic_pkg::*;
    logic          core_clk, reset, emu_req, pwrdn_req, m_enter, m_leave;
    logic          irq_req, emu_irq, status_valid, stack_fault;
    logic [5:0]    sq;
    logic [15:0]   reg_rdata, status_in, status_out, rv;
    logic [23:0]   irq_vector;
    logic [31:0]   periph_req;
    cpic_reg_req_t req;
    cpic_seq_t     seq;
    int            bad_count, compares, tcyc, n;
    assign seq = {m_enter, m_leave, sq};
    always #20 core_clk = ~core_clk;
    cpic_ctrl #(.NPER(32)) i_cpic_ctrl (
        .core_clk(core_clk), .reset(reset), .reg_req(req),
        .reg_rdata(reg_rdata), .periph_req(periph_req), .emu_req(emu_req),
        .pwrdn_req(pwrdn_req), .emu_kernel_req(1'b0), .seq(seq),
        .status_in(status_in), .irq_req(irq_req), .emu_irq(emu_irq),
        .irq_vector(irq_vector), .status_out(status_out),
        .status_valid(status_valid), .stack_fault(stack_fault)
    );
    cpic_seq_model i_cpic_seq_model (
        .core_clk(core_clk), .irq_req(irq_req), .irq_vector(irq_vector),
        .enter(m_enter), .leave(m_leave)
    );
    task automatic w(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask : w
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        req = '{1'b1, 1'b1, a, v};
        w(1);
        req = '0;
        w(1);
    endtask : wr
    task automatic rc(input logic [3:0] a, input logic [15:0] v,
                      input logic [15:0] m = 16'hFFFF);
        req = '{1'b1, 1'b0, a, 16'h0000};
        w(1);
        req = '0;
        w(1);
        chk(reg_rdata & m, v);
    endtask : rc
    task automatic pulse(input logic [31:0] m);
        periph_req = m;
        w(2);
        periph_req = '0;
    endtask : pulse
    task automatic vec(input int k, input int s);
        chk(i_cpic_seq_model.seen[k], 24'(s) * CPIC_VEC_STEP);
    endtask : vec
    task automatic cnt(input int c);
        chk(24'(i_cpic_seq_model.seen.size()), 24'(c));
    endtask : cnt
    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge core_clk) begin
        tcyc++;
        if (status_valid)
            chk(status_out, status_in);
        if (tcyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        req = '0;
        periph_req = '0;
        {emu_req, pwrdn_req} = 2'b00;
        sq = '0;
        status_in = 16'h0000;
        w(3);
        reset = 1'b0;
        rc(CPIC_A_CONTROL, 16'h0000);
        rc(CPIC_A_MASK, 16'h0000);
        for (int i = 0; i < 8; i++)
            rc(4'(8 + i), 16'hFFFF);
        wr(4'h5, 16'hFFFF);
        rc(4'h5, 16'h0000);
        wr(CPIC_A_MASK, 16'hFFF0);
        rc(CPIC_A_MASK, 16'hFFF0);
        wr(CPIC_A_CONTROL, 16'h0002);
        emu_req = 1'b1;
        w(5);
        chk(emu_irq, 24'h00_0001);
        emu_req = 1'b0;
        // every code once, sources spread over all registers and fields
        for (int i = 0; i < 16; i++) begin
            n = (i * 7 + 3) % 32;
            status_in = 16'(i) * 16'h0111;
            rv = 16'hFFFF ^ (16'(15 - i) << 4 * (n % 4));
            wr(4'(8 + n / 4), rv);
            pulse(32'(1) << n);
            w(30);
            cnt(i < 12 ? 1 : 0);
            if (i < 12)
                vec(0, 4 + i);
            i_cpic_seq_model.seen.delete();
            wr(4'(8 + n / 4), 16'hFFFF);
        end
        i_cpic_seq_model.lag = 3;
        wr(CPIC_A_ROUTE0, 16'h22F7);
        wr(CPIC_A_CONTROL, 16'h0000);
        pulse(32'h0000_0009);
        w(4);
        wr(CPIC_A_CONTROL, 16'h0002);
        w(60);
        vec(0, 6);
        vec(1, 11);
        wr(CPIC_A_MASK, 16'hFFB0);
        pulse(32'h0000_0009);
        w(40);
        vec(2, 11);
        wr(CPIC_A_MASK, 16'hFFF0);
        w(40);
        vec(3, 6);
        i_cpic_seq_model.seen.delete();
        for (int k = 0; k < 2; k++) begin
            wr(CPIC_A_CONTROL, 16'(2 + k));
            pulse(32'h0000_0001);
            w(8);
            pulse(32'h0000_0008);
            w(12);
            cnt(1 + k);
            w(50);
            i_cpic_seq_model.seen.delete();
        end
        wr(CPIC_A_PENDING, 16'h0020);
        w(12);
        vec(0, 5);
        w(30);
        wr(CPIC_A_CONTROL, 16'h0000);
        wr(CPIC_A_PENDING, 16'h0040);
        rc(CPIC_A_PENDING, 16'h0040, 16'hFFF0);
        wr(CPIC_A_PENDING, 16'h0000);
        rc(CPIC_A_PENDING, 16'h0000, 16'hFFF0);
        for (int j = 0; j < 2; j++) begin
            sq = j ? 6'b010000 : 6'b100000;
            w(1);
            sq = '0;
            pwrdn_req = 1'b1;
            w(3);
            pwrdn_req = 1'b0;
            w(30);
            cnt(2);
        end
        vec(1, 1);
        for (int i = 1; i < 35; i++) begin
            sq = 6'b001010;
            w(1);
            sq = '0;
            w(2);
            chk(stack_fault, 24'(i < 3 || i > 28));
        end
        rc(CPIC_A_STATUS, 16'h2180, 16'h3FF0);
        sq = 6'b000101;
        w(33);
        sq = '0;
        w(2);
        chk(stack_fault, 24'h00_0000);
        end_of_test();
    end
endmodule : cpic_ctrl_tb
bind cpic_ctrl cpic_ctrl_asserts i_cpic_ctrl_asserts (
    .core_clk(core_clk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .emu_req(emu_req), .seq(seq),
    .irq_req(irq_req), .emu_irq(emu_irq), .irq_vector(irq_vector),
    .status_valid(status_valid), .stack_fault(stack_fault)
);

// >>> testbench/cpic_seq_model.sv
// Purpose: program sequencer stand-in for cpic_ctrl
// Assumes: enter is pulsed only while irq_req stands
// Notes: each handler returns hold cycles after entry
`timescale 1ns/1ps
module cpic_seq_model (
    input  wire logic        core_clk,
    input  wire logic        irq_req,
    input  wire logic [23:0] irq_vector,
    output logic             enter,
    output logic             leave
);
    logic [23:0] seen[$];
    int          due[$];
    int          cyc = 0;
    int          wt = 0;
    int          lag = 0;
    int          hold = 20;
    logic        e;
    logic        l;
    initial enter = 1'b0;
    initial leave = 1'b0;
    // a slow sequencer leans on the request standing while it waits
    always @(posedge core_clk) begin
        cyc++;
        wt = (irq_req && !enter) ? wt + 1 : 0;
        e = wt > lag;
        if (e) begin
            seen.push_back(irq_vector);
            due.push_back(cyc + hold);
            wt = 0;
        end
        l = due.size() > 0 && due[0] <= cyc;
        if (l)
            void'(due.pop_front());
        #1;
        enter = e;
        leave = l;
    end
endmodule : cpic_seq_model
